/* core/swm_div.sv */
module swm_div #(
  parameter int NW = 36,
  parameter int DW = 18
) (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Synchronous reset, active high
  swm_div_if.div dv // Divide request and quotient
);
  localparam int CW = $clog2(NW + 1);

  logic [NW-1:0] quo_r;
  logic [DW-1:0] rem_r;
  logic [DW-1:0] den_r;
  logic neg_r;
  logic run_r;
  logic done_r;
  logic [CW-1:0] cnt_r;
  logic [DW:0] shl;
  logic [DW:0] diff;

  // Restoring division on magnitudes, sign applied at the end
  assign shl = {rem_r, quo_r[NW-1]};
  assign diff = shl - {1'b0, den_r};
  // Truncation toward zero follows from dividing magnitudes
  assign dv.quo = neg_r ? -$signed(quo_r) : $signed(quo_r);
  assign dv.done = done_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      quo_r <= '0;
      rem_r <= '0;
      den_r <= '0;
      neg_r <= 1'b0;
      run_r <= 1'b0;
      done_r <= 1'b0;
      cnt_r <= '0;
    end else begin
      done_r <= 1'b0;
      if (dv.start && !run_r) begin
        quo_r <= dv.num[NW-1] ? NW'(-dv.num) : NW'(dv.num);
        den_r <= dv.den[DW-1] ? DW'(-dv.den) : DW'(dv.den);
        rem_r <= '0;
        neg_r <= dv.num[NW-1] ^ dv.den[DW-1];
        cnt_r <= CW'(NW);
        run_r <= 1'b1;
      end else if (run_r) begin
        if (!diff[DW]) begin
          rem_r <= diff[DW-1:0];
          quo_r <= {quo_r[NW-2:0], 1'b1};
        end else begin
          rem_r <= shl[DW-1:0];
          quo_r <= {quo_r[NW-2:0], 1'b0};
        end
        cnt_r <= cnt_r - CW'(1);
        if (cnt_r == CW'(1)) begin
          run_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end
endmodule

/* core/swm_div_if.sv */
interface swm_div_if #(
  parameter int NW = 36,
  parameter int DW = 18
);
  logic start;
  logic signed [NW-1:0] num;
  logic signed [DW-1:0] den;
  logic done;
  logic signed [NW-1:0] quo;

  modport div (input start, input num, input den, output done, output quo);
  modport req (output start, output num, output den, input done, input quo);
endinterface

/* core/swm_pkg.sv */
package swm_pkg;

  typedef enum logic [2:0] {
    OP_MEAN,
    OP_INTERP,
    OP_MAG,
    OP_NEG,
    OP_LNEG
  } swm_op_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_MEAN_RD,
    ST_MEAN_DIV,
    ST_FG_X,
    ST_FG_Y,
    ST_FG_DIV
  } swm_state_t;

endpackage

/* core/swm_regs.svh */
`ifndef SWM_REGS_SVH
`define SWM_REGS_SVH

// Table limits
`define SWM_MEAN_MAX_WORDS 7'd64
`define SWM_FG_MAX_POINTS 7'd32

// Signed extremes
`define SWM_MIN16 16'h8000
`define SWM_MAX16 16'h7fff
`define SWM_MIN32 32'h80000000

`endif

/* core/swm_unit.sv */
`include "swm_regs.svh"

module swm_unit import swm_pkg::*; #(
  parameter int AW = 16,
  parameter int NW = 36,
  parameter int DW = 18
) (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic opEn, // Instruction enable, level
  input wire swm_op_t opSel, // Function select
  input wire logic [AW-1:0] tblBase, // First word of table
  input wire logic [6:0] tblSize, // Table words or breakpoint count
  input wire logic [15:0] argWord, // Source word or x
  input wire logic [31:0] argLong, // Long negate source, upper word high
  output logic memRdEn, // Table read strobe
  output logic [AW-1:0] memRdAddr, // Table read address
  input wire logic [15:0] memRdData, // Read data, cycle after strobe
  output logic [15:0] resWord, // Word result
  output logic [31:0] resLong, // Long result, upper word high
  output logic resValid, // Result strobe
  output logic busy, // Table operation in progress
  output logic outStatus // Output status
);
  swm_state_t state_r;
  swm_op_t opSel_r;
  logic [6:0] idx_r;
  logic [6:0] size_r;
  logic [AW-1:0] base_r;
  logic [AW-1:0] addr_r;
  logic rdWait_r;
  logic signed [21:0] sum_r;
  logic signed [15:0] x_r;
  logic signed [15:0] x0_r;
  logic signed [15:0] x1_r;
  logic signed [15:0] y0_r;
  logic signed [15:0] y1_r;
  logic direct_r;
  logic yCnt_r;
  logic [15:0] resWord_r;
  logic [31:0] resLong_r;
  logic resValid_r;
  logic outStatus_r;
  logic finish;
  logic [15:0] finWord;
  logic [31:0] finLong;
  logic signed [15:0] rdData;
  logic signed [16:0] dxv;
  logic signed [16:0] dyv;
  logic signed [16:0] spanv;
  logic signed [33:0] prod;

  swm_div_if #(.NW(NW), .DW(DW)) dv ();

  swm_div #(.NW(NW), .DW(DW)) u_div (
    .clk(clk),
    .sys_rst(sys_rst),
    .dv(dv.div)
  );

  function automatic logic [AW-1:0] addr_at(input logic [AW-1:0] base, input logic [7:0] off);
    addr_at = base + AW'(off);
  endfunction

  function automatic logic signed [16:0] sx17(input logic signed [15:0] v);
    sx17 = {v[15], v};
  endfunction

  function automatic logic [15:0] mag16(input logic [15:0] v);
    if (v == `SWM_MIN16) mag16 = `SWM_MAX16;
    else mag16 = v[15] ? -v : v;
  endfunction

  function automatic logic [15:0] neg16(input logic [15:0] v);
    neg16 = (v == `SWM_MIN16) ? v : -v;
  endfunction

  function automatic logic [31:0] neg32(input logic [31:0] v);
    neg32 = (v == `SWM_MIN32) ? v : -v;
  endfunction

  assign rdData = $signed(memRdData);
  // Products fit 34 bits; breakpoints strictly bracket x here, so span is non-zero
  assign dxv = sx17(x_r) - sx17(x0_r);
  assign dyv = sx17(rdData) - sx17(y0_r);
  assign spanv = sx17(x1_r) - sx17(x0_r);
  assign prod = dxv * dyv;

  assign memRdEn = (state_r inside {ST_MEAN_RD, ST_FG_X, ST_FG_Y}) && !rdWait_r;
  assign memRdAddr = addr_r;
  assign busy = (state_r != ST_IDLE);
  assign resWord = resWord_r;
  assign resLong = resLong_r;
  assign resValid = resValid_r;
  assign outStatus = outStatus_r;

  always_comb begin
    finish = 1'b0;
    finWord = resWord_r;
    finLong = resLong_r;
    case (state_r)
      ST_IDLE: begin
        if (opEn) begin
          case (opSel)
            OP_MAG: begin
              finish = 1'b1;
              finWord = mag16(argWord);
            end
            OP_NEG: begin
              finish = 1'b1;
              finWord = neg16(argWord);
            end
            OP_LNEG: begin
              finish = 1'b1;
              finLong = neg32(argLong);
              finWord = finLong[15:0];
            end
            default: finish = 1'b0;
          endcase
        end
      end
      ST_MEAN_DIV: begin
        if (dv.done) begin
          finish = 1'b1;
          finWord = dv.quo[15:0];
        end
      end
      ST_FG_Y: begin
        if (rdWait_r && direct_r) begin
          finish = 1'b1;
          finWord = memRdData;
        end
      end
      ST_FG_DIV: begin
        if (dv.done) begin
          finish = 1'b1;
          finWord = y0_r + dv.quo[15:0];
        end
      end
      default: finish = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      opSel_r <= OP_MEAN;
      idx_r <= '0;
      size_r <= '0;
      base_r <= '0;
      addr_r <= '0;
      rdWait_r <= 1'b0;
      sum_r <= '0;
      x_r <= '0;
      x0_r <= '0;
      x1_r <= '0;
      y0_r <= '0;
      y1_r <= '0;
      direct_r <= 1'b0;
      yCnt_r <= 1'b0;
      dv.start <= 1'b0;
      dv.num <= '0;
      dv.den <= '0;
    end else begin
      dv.start <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          rdWait_r <= 1'b0;
          // Inactive enable leaves the state and operand registers untouched
          if (opEn) begin
            opSel_r <= opSel;
            base_r <= tblBase;
            size_r <= tblSize;
            x_r <= argWord;
            addr_r <= tblBase;
            idx_r <= '0;
            sum_r <= '0;
            if (opSel == OP_MEAN) state_r <= ST_MEAN_RD;
            else if (opSel == OP_INTERP) state_r <= ST_FG_X;
          end
        end
        ST_MEAN_RD: begin
          if (!rdWait_r) rdWait_r <= 1'b1;
          else begin
            rdWait_r <= 1'b0;
            sum_r <= sum_r + 22'(rdData);
            idx_r <= idx_r + 7'd1;
            addr_r <= addr_r + AW'(1);
            // Size zero is outside the allowed range and wraps to 128 reads
            if (idx_r == size_r - 7'd1) begin
              dv.start <= 1'b1;
              dv.num <= NW'(sum_r + 22'(rdData));
              dv.den <= DW'($signed({1'b0, size_r}));
              state_r <= ST_MEAN_DIV;
            end
          end
        end
        ST_MEAN_DIV: begin
          if (dv.done) state_r <= ST_IDLE;
        end
        ST_FG_X: begin
          if (!rdWait_r) rdWait_r <= 1'b1;
          else begin
            rdWait_r <= 1'b0;
            // First breakpoint not below x decides; relies on ordered table
            if (x_r <= rdData) begin
              yCnt_r <= 1'b0;
              state_r <= ST_FG_Y;
              if (idx_r == 7'd0 || x_r == rdData) begin
                direct_r <= 1'b1;
                addr_r <= addr_at(base_r, 8'(size_r) + 8'(idx_r));
              end else begin
                direct_r <= 1'b0;
                x1_r <= rdData;
                addr_r <= addr_at(base_r, 8'(size_r) + 8'(idx_r) - 8'd1);
              end
            end else begin
              x0_r <= rdData;
              if (idx_r == size_r - 7'd1) begin
                direct_r <= 1'b1;
                yCnt_r <= 1'b0;
                addr_r <= addr_at(base_r, 8'(size_r) + 8'(idx_r));
                state_r <= ST_FG_Y;
              end else begin
                idx_r <= idx_r + 7'd1;
                addr_r <= addr_r + AW'(1);
              end
            end
          end
        end
        ST_FG_Y: begin
          if (!rdWait_r) rdWait_r <= 1'b1;
          else begin
            rdWait_r <= 1'b0;
            if (direct_r) state_r <= ST_IDLE;
            else if (!yCnt_r) begin
              y0_r <= rdData;
              yCnt_r <= 1'b1;
              addr_r <= addr_r + AW'(1);
            end else begin
              y1_r <= rdData;
              dv.start <= 1'b1;
              dv.num <= NW'(prod);
              dv.den <= DW'(spanv);
              state_r <= ST_FG_DIV;
            end
          end
        end
        ST_FG_DIV: begin
          if (dv.done) state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      resValid_r <= 1'b0;
      resWord_r <= '0;
      resLong_r <= '0;
      outStatus_r <= 1'b0;
    end else begin
      resValid_r <= finish;
      if (finish) begin
        resWord_r <= finWord;
        resLong_r <= finLong;
        outStatus_r <= opEn;
      end else if (!opEn) outStatus_r <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_single(swm_op_t op);
    state_r == ST_IDLE && opEn && opSel == op;
  endsequence

  sequence s_table_start(swm_op_t op);
    state_r == ST_IDLE && opEn && opSel == op && tblSize != 7'd0;
  endsequence

  property p_mag_pos;
    s_single(OP_MAG) and !argWord[15] |=> resValid && resWord == $past(argWord);
  endproperty
  a_mag_pos: assert property (p_mag_pos) else $error("magnitude of positive word wrong");

  property p_mag_sat;
    s_single(OP_MAG) and argWord == 16'h8000 |=> resValid && resWord == 16'h7fff;
  endproperty
  a_mag_sat: assert property (p_mag_sat) else $error("magnitude did not saturate");

  property p_neg;
    s_single(OP_NEG) and argWord != 16'h8000 |=> resValid && 16'(resWord + $past(argWord)) == 16'h0000;
  endproperty
  a_neg: assert property (p_neg) else $error("word negate wrong");

  property p_neg_min;
    s_single(OP_NEG) and argWord == 16'h8000 |=> resWord == 16'h8000;
  endproperty
  a_neg_min: assert property (p_neg_min) else $error("word negate of minimum changed");

  property p_lneg;
    s_single(OP_LNEG) |=> resValid && 32'(resLong + $past(argLong)) == 32'h00000000;
  endproperty
  a_lneg: assert property (p_lneg) else $error("long negate wrong");

  property p_status_low;
    !opEn |=> !outStatus;
  endproperty
  a_status_low: assert property (p_status_low) else $error("status high without enable");

  property p_status_hi;
    resValid |-> outStatus == $past(opEn);
  endproperty
  a_status_hi: assert property (p_status_hi) else $error("status not set by executed result");

  property p_mean_done;
    s_table_start(OP_MEAN) |=> busy ##[1:200] resValid;
  endproperty
  a_mean_done: assert property (p_mean_done) else $error("mean never finished");

  property p_fg_addr;
    memRdEn && opSel_r == OP_INTERP |-> 8'(memRdAddr - base_r) < 8'({size_r, 1'b0});
  endproperty
  a_fg_addr: assert property (p_fg_addr) else $error("interpolator read outside table");

  property p_fg_between;
    state_r == ST_FG_DIV && dv.done |=>
      (($signed(resWord) >= y0_r && $signed(resWord) <= y1_r) ||
       ($signed(resWord) <= y0_r && $signed(resWord) >= y1_r));
  endproperty
  a_fg_between: assert property (p_fg_between) else $error("interpolated value outside its pair");
endmodule

/* verif/swm_mem_model.sv */
module swm_mem_model #(
  parameter int AW = 16
) (
  input wire logic clk, // System clock
  input wire logic memRdEn, // Read strobe
  input wire logic [AW-1:0] memRdAddr, // Read address
  output logic [15:0] memRdData // Word in the cycle after the strobe
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [15:0] mem [0:511];

  task automatic setWord(input logic [8:0] a, input logic [15:0] d);
    mem[a] = d;
  endtask

  // Outside the data cycle the bus flips so a late sample cannot see a stale word
  always_ff @(posedge clk) begin
    if (memRdEn)
      memRdData <= mem[memRdAddr[8:0]];
    else
      memRdData <= ~memRdData;
  end
endmodule

/* verif/testbench.sv */
module testbench import swm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk = 1'b0;
  logic sysRst = 1'b1;
  logic opEn = 1'b0;
  swm_op_t opSel = OP_MAG;
  logic [15:0] tblBase = 16'h0000;
  logic [6:0] tblSize = 7'h01;
  logic [15:0] argWord = 16'h0000;
  logic [31:0] argLong = 32'h00000000;
  logic memRdEn;
  logic [15:0] memRdAddr;
  logic [15:0] memRdData;
  logic [15:0] resWord;
  logic [31:0] resLong;
  logic resValid;
  logic busy;
  logic outStatus;
  int numErrors = 0;
  int checksDone = 0;
  int cycles = 0;
  int rdSeen = 0;

  swm_unit swm_unit_inst (
    .clk(clk), .sys_rst(sysRst), .opEn(opEn), .opSel(opSel), .tblBase(tblBase),
    .tblSize(tblSize), .argWord(argWord), .argLong(argLong), .memRdEn(memRdEn),
    .memRdAddr(memRdAddr), .memRdData(memRdData), .resWord(resWord), .resLong(resLong),
    .resValid(resValid), .busy(busy), .outStatus(outStatus)
  );

  swm_mem_model swm_mem_model_inst (
    .clk(clk), .memRdEn(memRdEn), .memRdAddr(memRdAddr), .memRdData(memRdData)
  );

  always #50 clk = ~clk;

  task automatic summarize();
    $display("Errors %0d, checks %0d", numErrors, checksDone);
    if (numErrors == 0 && checksDone > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Longest run is well under 3000 cycles
  always @(posedge clk) begin
    cycles++;
    if (memRdEn === 1'b1)
      rdSeen++;
    if (cycles == 20000) begin
      numErrors++;
      $display("ERROR timeout expected finish seen hang");
      summarize();
    end
  end

  task automatic checkVal(input string name, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      numErrors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic checkBit(input string name, input logic exp, input logic got);
    checksDone++;
    if (got !== exp) begin
      numErrors++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask

  // Enable held until the result, then dropped before the next idle edge
  task automatic runOp(input swm_op_t op, input logic [15:0] base, input logic [6:0] size,
                       input logic [15:0] word, input logic [31:0] lng, input logic [31:0] exp);
    int lat;
    lat = 0;
    opSel = op;
    tblBase = base;
    tblSize = size;
    argWord = word;
    argLong = lng;
    opEn = 1'b1;
    rdSeen = 0;
    do begin
      @(posedge clk);
      #1;
      lat++;
    end while (resValid !== 1'b1 && lat < 400);
    opEn = 1'b0;
    if (op == OP_MEAN || op == OP_INTERP)
      checkBit("answer in time", 1'b1, lat <= 200);
    else
      checkVal("single latency", 32'd1, 32'(lat));
    if (op == OP_LNEG) begin
      checkVal("long result", exp, resLong);
      checkVal("long low word", {16'h0000, exp[15:0]}, {16'h0000, resWord});
    end else begin
      checkVal("word result", {16'h0000, exp[15:0]}, {16'h0000, resWord});
    end
    checkBit("status on", 1'b1, outStatus);
    @(posedge clk);
    #1;
    checkBit("valid pulse", 1'b0, resValid);
    checkBit("idle again", 1'b0, busy);
    @(posedge clk);
    #1;
    checkBit("status off", 1'b0, outStatus);
  endtask

  task automatic testReset();
    checkVal("reset word", 32'h0, {16'h0000, resWord});
    checkVal("reset long", 32'h0, resLong);
    checkBit("reset status", 1'b0, outStatus);
    checkBit("reset busy", 1'b0, busy);
  endtask

  task automatic testIdle();
    logic [15:0] held;
    held = resWord;
    repeat (5) begin
      opSel = OP_NEG;
      argWord = argWord + 16'h1111;
      @(posedge clk);
      #1;
      checkBit("valid while off", 1'b0, resValid);
      checkBit("status while off", 1'b0, outStatus);
    end
    checkVal("word held", {16'h0000, held}, {16'h0000, resWord});
  endtask

  task automatic testMagnitude();
    runOp(OP_MAG, 16'h0, 7'h1, 16'hd120, 32'h0, 32'h2ee0);
    runOp(OP_MAG, 16'h0, 7'h1, 16'h8000, 32'h0, 32'h7fff);
    runOp(OP_MAG, 16'h0, 7'h1, 16'h7fff, 32'h0, 32'h7fff);
  endtask

  task automatic testNegate();
    runOp(OP_NEG, 16'h0, 7'h1, 16'h1234, 32'h0, 32'hedcc);
    runOp(OP_NEG, 16'h0, 7'h1, 16'h8000, 32'h0, 32'h8000);
    runOp(OP_NEG, 16'h0, 7'h1, 16'h0000, 32'h0, 32'h0000);
  endtask

  task automatic testLongNegate();
    runOp(OP_LNEG, 16'h0, 7'h1, 16'h0, 32'hb669fd2e, 32'h499602d2);
    runOp(OP_LNEG, 16'h0, 7'h1, 16'h0, 32'h80000000, 32'h80000000);
    runOp(OP_LNEG, 16'h0, 7'h1, 16'h0, 32'h0000ffff, 32'hffff0001);
  endtask

  task automatic testMean();
    for (int i = 0; i < 10; i++)
      swm_mem_model_inst.setWord(9'(i), 16'(i * 100 - 300));
    for (int i = 0; i < 63; i++)
      swm_mem_model_inst.setWord(9'(256 + i), 16'h7fff);
    swm_mem_model_inst.setWord(9'h13f, 16'h8000);
    swm_mem_model_inst.setWord(9'h040, 16'hffff);
    swm_mem_model_inst.setWord(9'h041, 16'hffff);
    swm_mem_model_inst.setWord(9'h042, 16'h0000);
    runOp(OP_MEAN, 16'h0000, 7'd10, 16'h0, 32'h0, 32'h0096);
    checkVal("mean reads", 32'd10, 32'(rdSeen));
    runOp(OP_MEAN, 16'h0000, 7'd1, 16'h0, 32'h0, 32'hfed4);
    checkVal("mean reads", 32'd1, 32'(rdSeen));
    runOp(OP_MEAN, 16'h0100, 7'd64, 16'h0, 32'h0, 32'h7bff);
    checkVal("mean reads", 32'd64, 32'(rdSeen));
    runOp(OP_MEAN, 16'h0040, 7'd3, 16'h0, 32'h0, 32'h0000);
  endtask

  task automatic testInterp();
    logic [15:0] tbl [8];
    tbl = '{16'hf830, 16'hff9c, 16'h0064, 16'h07d0, 16'hf8f8, 16'hfed4, 16'h012c, 16'h0708};
    for (int i = 0; i < 8; i++)
      swm_mem_model_inst.setWord(9'(128 + i), tbl[i]);
    swm_mem_model_inst.setWord(9'h090, 16'h0000);
    swm_mem_model_inst.setWord(9'h091, 16'h0003);
    swm_mem_model_inst.setWord(9'h092, 16'h0000);
    swm_mem_model_inst.setWord(9'h093, 16'hfff6);
    swm_mem_model_inst.setWord(9'h0a0, 16'h8000);
    swm_mem_model_inst.setWord(9'h0a1, 16'h7fff);
    swm_mem_model_inst.setWord(9'h0a2, 16'h8000);
    swm_mem_model_inst.setWord(9'h0a3, 16'h7fff);
    runOp(OP_INTERP, 16'h0080, 7'd4, 16'h05dc, 32'h0, 32'h057d);
    runOp(OP_INTERP, 16'h0080, 7'd4, 16'hff6a, 32'h0, 32'hfeac);
    runOp(OP_INTERP, 16'h0080, 7'd4, 16'hf830, 32'h0, 32'hf8f8);
    runOp(OP_INTERP, 16'h0080, 7'd4, 16'hf63c, 32'h0, 32'hf8f8);
    runOp(OP_INTERP, 16'h0080, 7'd4, 16'h09c4, 32'h0, 32'h0708);
    runOp(OP_INTERP, 16'h0080, 7'd4, 16'h8000, 32'h0, 32'hf8f8);
    runOp(OP_INTERP, 16'h0080, 7'd4, 16'h7fff, 32'h0, 32'h0708);
    runOp(OP_INTERP, 16'h0090, 7'd2, 16'h0001, 32'h0, 32'hfffd);
    runOp(OP_INTERP, 16'h00a0, 7'd2, 16'h0000, 32'h0, 32'h0000);
  endtask

  initial begin
    repeat (4) @(posedge clk);
    #1;
    testReset();
    sysRst = 1'b0;
    testMagnitude();
    testIdle();
    testNegate();
    testLongNegate();
    testMean();
    testInterp();
    summarize();
  end
endmodule
